// ### hw/mmd_pkg.sv
package mmd_pkg;
    // Address space and region bounds
    localparam int          ADDR_W       = 16;
    localparam logic [15:0] IO_LO        = 16'h0000;
    localparam logic [15:0] IO_HI        = 16'h007F;
    localparam logic [15:0] XIO_LO       = 16'h0F80;
    localparam logic [15:0] XIO_HI       = 16'h0FFF;
    localparam logic [15:0] RAM_LO       = 16'h0080;
    localparam logic [15:0] DIR_RAM_LO   = 16'h0090;
    localparam logic [15:0] DIR_RAM_HI   = 16'h00FF;
    localparam logic [15:0] GPR_LO       = 16'h0100;
    localparam logic [15:0] GPR_HI       = 16'h01FF;
    localparam logic [15:0] NVR_LO       = 16'hFFBB;
    localparam logic [15:0] NVR_HI       = 16'hFFBF;
    localparam logic [15:0] VEC_LO       = 16'hFFC0;
    localparam logic [15:0] VEC_HI       = 16'hFFFF;
    // Default top of implemented RAM (largest variant)
    localparam logic [15:0] RAM_TOP_DEF  = 16'h047F;
    // Lowest flash address decoded as program code
    localparam logic [15:0] FLASH_LO_DEF = 16'h8000;
    // Bank pointer
    localparam int          BANK_W       = 3;
    localparam logic [2:0]  BANK_RST     = 3'h0;
    // Bank window base is 0x0080 plus bank times 128
    localparam int          WIN_SHIFT    = 7;

    // Target region selected for an access
    typedef enum logic [2:0] {
        MMD_NONE, MMD_IO, MMD_XIO, MMD_RAM, MMD_NVR, MMD_VEC, MMD_CODE
    } mmd_region_e;

    // Request from the CPU core
    typedef struct packed {
        logic        valid;   // Access present
        logic        direct;  // Operand is a direct-addressing operand
        logic [7:0]  operand; // Direct operand (when direct)
        logic [15:0] addr;    // Ordinary address (when not direct)
    } mmd_req_s;

    // Decoded result
    typedef struct packed {
        logic        valid;   // Result present
        mmd_region_e region;  // Target region
        logic [15:0] phys;    // Physical address
        logic        gpr;     // Inside general-purpose register window
        logic        vec;     // Read is a vector entry holding a start address
    } mmd_dec_s;
endpackage

// ### hw/mmd_decoder.sv
`timescale 1ns/1ps
module mmd_decoder #(
    parameter logic [15:0] RAM_TOP  = mmd_pkg::RAM_TOP_DEF,
    parameter logic [15:0] FLASH_LO = mmd_pkg::FLASH_LO_DEF
) (
    input  wire logic                        clock,
    input  wire logic                        srst,
    input  wire mmd_pkg::mmd_req_s           req,
    input  wire logic                        bank_we,
    input  wire logic [mmd_pkg::BANK_W-1:0]  bank_wdata,
    output      logic [mmd_pkg::BANK_W-1:0]  direct_bank_pointer,
    output      mmd_pkg::mmd_dec_s           dec
);

    logic [mmd_pkg::BANK_W-1:0] bank_q;   // Direct bank pointer state
    logic [15:0]                eff;      // Effective address after banking
    mmd_pkg::mmd_region_e       region;   // Combinational region
    logic                       gpr_hit;  // Window hit
    logic                       vec_hit;  // Vector table hit
    mmd_pkg::mmd_dec_s          dec_q;    // Registered result

    assign direct_bank_pointer = bank_q;

    // Bank pointer; written by the core, zero after reset
    always_ff @(posedge clock) begin
        if (srst) begin
            bank_q <= mmd_pkg::BANK_RST;
        end else if (bank_we) begin
            bank_q <= bank_wdata;
        end
    end

    // Direct operand translation into a physical address
    always_comb begin
        eff = req.addr;
        if (req.direct) begin
            if (req.operand[7] == 1'b0) begin
                // Low half always reaches the I/O area
                eff = {8'h00, req.operand};
            end else if (bank_q == mmd_pkg::BANK_RST) begin
                // Pointer zero leaves the operand where it is
                eff = {8'h00, req.operand};
            end else begin
                // Window base 0x0080 + bank*128, offset from low seven bits
                eff = mmd_pkg::RAM_LO
                    + {6'h00, bank_q, 7'h00}
                    + {9'h000, req.operand[6:0]};
            end
        end
    end

    // Region decode over the whole 16-bit space
    always_comb begin
        region  = mmd_pkg::MMD_NONE;
        gpr_hit = 1'b0;
        vec_hit = 1'b0;
        if (eff <= mmd_pkg::IO_HI) begin
            region = mmd_pkg::MMD_IO;
        end else if (eff >= mmd_pkg::XIO_LO && eff <= mmd_pkg::XIO_HI) begin
            region = mmd_pkg::MMD_XIO;
        end else if (eff >= mmd_pkg::RAM_LO && eff <= RAM_TOP) begin
            // Only implemented RAM decodes; anything above it below the extended I/O at 0x0F80 is a hole
            region  = mmd_pkg::MMD_RAM;
            gpr_hit = (eff >= mmd_pkg::GPR_LO) && (eff <= mmd_pkg::GPR_HI);
        end else if (eff >= mmd_pkg::VEC_LO) begin
            // Checked before code so the table never reads as plain flash
            region  = mmd_pkg::MMD_VEC;
            vec_hit = 1'b1;
        end else if (eff >= mmd_pkg::NVR_LO && eff <= mmd_pkg::NVR_HI) begin
            region = mmd_pkg::MMD_NVR;
        end else if (eff >= FLASH_LO) begin
            region = mmd_pkg::MMD_CODE;
        end else begin
            region = mmd_pkg::MMD_NONE;
        end
    end

    // Result register; data outputs come from flip-flops
    always_ff @(posedge clock) begin
        if (srst) begin
            dec_q <= '0;
        end else begin
            dec_q.valid  <= req.valid;
            dec_q.region <= region;
            dec_q.phys   <= eff;
            dec_q.gpr    <= gpr_hit;
            dec_q.vec    <= vec_hit;
        end
    end

    assign dec = dec_q;

    // Pointer is zero after reset
    property p_bank_reset;
        @(posedge clock) $past(srst) |-> (bank_q == 3'h0);
    endproperty
    a_bank_reset: assert property (p_bank_reset)
        else $error("bank pointer not zero after reset");

    // I/O range decodes to the I/O region
    property p_io;
        @(posedge clock) disable iff (srst)
        (req.valid && eff <= 16'h007F) |=> (dec.region == mmd_pkg::MMD_IO);
    endproperty
    a_io: assert property (p_io)
        else $error("I/O address misdecoded");

    // Extended I/O range
    property p_xio;
        @(posedge clock) disable iff (srst)
        (eff >= 16'h0F80 && eff <= 16'h0FFF) |=> (dec.region == mmd_pkg::MMD_XIO);
    endproperty
    a_xio: assert property (p_xio)
        else $error("extended I/O misdecoded");

    // Low direct operands ignore the pointer
    property p_direct_low;
        @(posedge clock) disable iff (srst)
        (req.direct && !req.operand[7]) |=> (dec.phys == {8'h00, $past(req.operand)});
    endproperty
    a_direct_low: assert property (p_direct_low)
        else $error("low direct operand was banked");

    // Pointer zero maps high operands to themselves
    property p_direct_zero;
        @(posedge clock) disable iff (srst)
        (req.direct && req.operand[7] && bank_q == 3'h0)
            |=> (dec.phys == {8'h00, $past(req.operand)});
    endproperty
    a_direct_zero: assert property (p_direct_zero)
        else $error("pointer zero translated operand");

    // Banked operand lands in window 0x0080 + bank*128
    property p_window;
        @(posedge clock) disable iff (srst)
        (req.direct && req.operand[7] && bank_q != 3'h0)
            |=> (dec.phys[15:7] == {5'h00, $past(bank_q)} + 9'h001)
             && (dec.phys[6:0] == $past(req.operand[6:0]));
    endproperty
    a_window: assert property (p_window)
        else $error("bank window address wrong");

    // Register window flag
    property p_gpr;
        @(posedge clock) disable iff (srst)
        (dec.region == mmd_pkg::MMD_RAM && dec.phys[15:8] == 8'h01) |-> dec.gpr;
    endproperty
    a_gpr: assert property (p_gpr)
        else $error("register window not flagged");

    // Vector table
    property p_vec;
        @(posedge clock) disable iff (srst)
        (eff >= 16'hFFC0) |=> (dec.region == mmd_pkg::MMD_VEC) && dec.vec;
    endproperty
    a_vec: assert property (p_vec)
        else $error("vector table misdecoded");

    // Non-volatile register data
    property p_nvr;
        @(posedge clock) disable iff (srst)
        (eff >= 16'hFFBB && eff <= 16'hFFBF) |=> (dec.region == mmd_pkg::MMD_NVR);
    endproperty
    a_nvr: assert property (p_nvr)
        else $error("non-volatile area misdecoded");

    // Above implemented RAM never decodes as RAM
    property p_hole;
        @(posedge clock) disable iff (srst)
        (eff > RAM_TOP && eff < 16'h0F80) |=> (dec.region == mmd_pkg::MMD_NONE);
    endproperty
    a_hole: assert property (p_hole)
        else $error("access aliased past RAM top");

endmodule

// ### sim/mmd_cpu_model.sv
`timescale 1ns/1ps
// Stand-in for the CPU core: one access and at most one pointer write per call
module mmd_cpu_model (
    input  wire logic              clock,
    output      mmd_pkg::mmd_req_s req,
    output      logic              bank_we,
    output      logic [2:0]        bank_wdata
);
    // Idle at time zero so the decoder never samples unknowns
    initial begin
        req        = '0;
        bank_we    = 1'b0;
        bank_wdata = 3'h0;
    end

    // Drive just after the edge; values stand until the next call
    task automatic issue(input mmd_pkg::mmd_req_s r, input logic we, input logic [2:0] wd);
        @(posedge clock);
        #1;
        req        = r;
        bank_we    = we;
        bank_wdata = wd;
    endtask
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [15:0] TOP = 16'h028F;   // Smallest RAM variant, so the top banks overrun
    logic              clock = 1'b0;          // 40 MHz
    logic              srst  = 1'b1;          // Held for 3 cycles
    mmd_pkg::mmd_req_s req;                   // Request from the core model
    logic              bank_we;               // Pointer write strobe
    logic [2:0]        bank_wdata;            // Pointer write value
    logic [2:0]        direct_bank_pointer;   // Pointer seen at the port
    logic [2:0]        ptr_exp = 3'h0;        // Pointer that the rules predict
    mmd_pkg::mmd_dec_s dec;                   // Decoded result
    mmd_pkg::mmd_dec_s exp_q[$];              // Expected results, oldest first
    int                miscompares = 0;
    int                n_compared  = 0;
    int                cycles      = 0;
    int                seed        = 84557;
    logic [15:0]       addrs[22] = '{16'h0000, 16'h007F, 16'h0080, 16'h008F, 16'h0090,
        16'h00FF, 16'h0100, 16'h01FF, 16'h0200, 16'h028F, 16'h0290, 16'h0F7F, 16'h0F80,
        16'h0FFF, 16'h1000, 16'h7FFF, 16'h8000, 16'hFFBA, 16'hFFBB, 16'hFFBF, 16'hFFC0, 16'hFFFF};
    logic [7:0]        ops[6] = '{8'h00, 8'h7F, 8'h80, 8'h8F, 8'h90, 8'hFF};

    always #12.5 clock = ~clock;

    mmd_cpu_model u_cpu (.clock(clock), .req(req), .bank_we(bank_we), .bank_wdata(bank_wdata));
    mmd_decoder #(.RAM_TOP(TOP)) u_dut (.clock(clock), .srst(srst), .req(req),
        .bank_we(bank_we), .bank_wdata(bank_wdata),
        .direct_bank_pointer(direct_bank_pointer), .dec(dec));

    // Decode as the memory map demands; a write in the same cycle is not yet seen
    function automatic mmd_pkg::mmd_dec_s model(input mmd_pkg::mmd_req_s r, input logic [2:0] b);
        mmd_pkg::mmd_dec_s d;
        logic [15:0]       a;
        a = r.addr;
        if (r.direct) begin
            a = (r.operand < 8'h80 || b == 3'h0) ? {8'h00, r.operand}
                : 16'h0080 + {6'h00, b, 7'h00} + {9'h000, r.operand[6:0]};
        end
        d.valid = r.valid;
        d.phys  = a;
        d.gpr   = (a >= 16'h0100) && (a <= 16'h01FF);
        if (a <= 16'h007F) d.region = mmd_pkg::MMD_IO;
        else if (a <= TOP) d.region = mmd_pkg::MMD_RAM;
        else if (a >= 16'h0F80 && a <= 16'h0FFF) d.region = mmd_pkg::MMD_XIO;
        else if (a >= 16'hFFC0) d.region = mmd_pkg::MMD_VEC;
        else if (a >= 16'hFFBB) d.region = mmd_pkg::MMD_NVR;
        else if (a >= 16'h8000) d.region = mmd_pkg::MMD_CODE;
        else d.region = mmd_pkg::MMD_NONE;
        d.vec = (d.region == mmd_pkg::MMD_VEC);
        return d;
    endfunction

    task automatic check(input logic [21:0] seen, input logic [21:0] want);
        n_compared++;
        if (seen !== want) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Issue one access and note what it must decode to
    task automatic send(input mmd_pkg::mmd_req_s r, input logic we, input logic [2:0] wd);
        u_cpu.issue(r, we, wd);
        if (r.valid) exp_q.push_back(model(r, ptr_exp));
    endtask

    // Pointer prediction follows the write strobe, cleared by reset
    always @(posedge clock) begin
        if (srst) ptr_exp <= 3'h0;
        else if (bank_we) ptr_exp <= bank_wdata;
    end

    // Watcher: results are settled mid-cycle; also guards against a hang
    always @(negedge clock) begin
        cycles++;
        if (cycles > 2000) begin
            miscompares++;
            conclude();
        end
        if (!srst) begin
            check({19'h0, direct_bank_pointer}, {19'h0, ptr_exp});
            if (dec.valid === 1'b1) begin
                if (exp_q.size() == 0) check(dec, '0);
                else check(dec, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (3) @(posedge clock);
        #1;
        srst = 1'b0;
        check(dec, '0);
        // Every region boundary by ordinary address
        foreach (addrs[i]) send('{1'b1, 1'b0, 8'($random(seed)), addrs[i]}, 1'b0, 3'h0);
        // Each bank, written in the same cycle as a direct access that must see the old value
        for (int b = 0; b < 8; b++) begin
            send('{1'b1, 1'b1, 8'h90, 16'($random(seed))}, 1'b1, 3'(b));
            foreach (ops[i]) send('{1'b1, 1'b1, ops[i], 16'($random(seed))}, 1'b0, 3'h0);
        end
        // Random mix, back to back, with idle slots and pointer writes
        repeat (300) send(26'($random(seed)), 1'($random(seed)), 3'($random(seed)));
        send('0, 1'b0, 3'h0);
        repeat (3) @(posedge clock);
        if (exp_q.size() != 0) check(22'(exp_q.size()), '0);
        conclude();
    end
endmodule
